// ===== verilog/tcoc_top.sv
// Purpose: capture/compare control, output control and count clock select of a 16-bit timer
// Assumes: one 250 MHz clock; capture trigger pin is asynchronous
// Notes: register reads answer one cycle after the read strobe
`include "tcoc_defines.svh"
module tcoc_top
   import tcoc_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic capture_pin_i,
   input wire logic ext_count_pin_i,
   input wire logic internal_ring_oscillator_cpu_i,
   input wire logic ring_tick_i,
   output logic [7:0] rdata_o,
   output logic timer_out_o,
   output logic running_o
);
   tcoc_bus_s bus;
   assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

   // registers
   logic [7:0] timer_mode_control, next_timer_mode_control;
   logic [7:0] capture_compare_control, next_capture_compare_control;
   logic [7:0] output_control, next_output_control;
   logic [7:0] prescaler_select, next_prescaler_select;
   logic [15:0] compare_capture_reg_a, next_compare_capture_reg_a;
   logic [15:0] compare_reg_b, next_compare_reg_b;
   logic [15:0] timer_count_value, next_timer_count_value;
   logic [15:0] presc_cnt, next_presc_cnt;
   logic ovf, next_ovf;
   logic out_ff, next_out_ff;
   logic one_shot_active, next_one_shot_active;
   logic [7:0] rdata, next_rdata;
   logic [7:0] cap_lo_latch, next_cap_lo_latch;
   logic [1:0] cap_sync, ext_sync;
   logic cap_prev, ext_prev;
   tcoc_run_e run_state, next_run_state;

   function automatic logic [15:0] presc_div(input logic [1:0] sel);
      presc_div = 16'h0001 << {sel, 2'b00};
   endfunction

   function automatic logic is_addr(input logic [3:0] a, input logic [3:0] ref_a);
      is_addr = (a == ref_a);
   endfunction

   logic op_bits_nonzero;
   logic count_tick;
   logic cap_edge;
   logic ext_edge;
   logic match_a;
   logic match_b;
   logic ring_sel;
   logic clr_on_a;
   logic cap_a_en;
   logic ovf_set;

   assign op_bits_nonzero = timer_mode_control[`TCOC_MODE_OPL] | timer_mode_control[`TCOC_MODE_OPH];
   assign ring_sel = prescaler_select[`TCOC_PRE_RING] | internal_ring_oscillator_cpu_i;
   assign clr_on_a = timer_mode_control[`TCOC_MODE_CLRA];
   // capture on a is ignored while clear-on-match-a is selected
   assign cap_a_en = capture_compare_control[`TCOC_CAP_A] & ~clr_on_a;
   assign cap_edge = cap_sync[1] & ~cap_prev;
   assign ext_edge = ext_sync[1] & ~ext_prev;
   assign match_a = (timer_count_value == compare_capture_reg_a) && !cap_a_en;
   assign match_b = (timer_count_value == compare_reg_b);
   assign ovf_set = op_bits_nonzero && count_tick && (timer_count_value == `TCOC_CNT_MAX);

   // pin synchronisers; external input sampled by ring ticks when ring clock is on the cpu
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         cap_sync <= 2'b00;
         ext_sync <= 2'b00;
         cap_prev <= 1'b0;
         ext_prev <= 1'b0;
      end
      else
      begin
         cap_sync <= {cap_sync[0], capture_pin_i};
         cap_prev <= cap_sync[1];
         if (!internal_ring_oscillator_cpu_i || ring_tick_i)
         begin
            ext_sync <= {ext_sync[0], ext_count_pin_i};
            ext_prev <= ext_sync[1];
         end
      end
   end

   // count tick: external pin edge, prescaled system clock or divided ring oscillator
   always_comb
   begin
      count_tick = 1'b0;
      next_presc_cnt = presc_cnt;
      if (op_bits_nonzero)
      begin
         // with the ring clock on the cpu the external edge only counts on a ring tick
         if (prescaler_select[1:0] == `TCOC_PRE_EXT)
            count_tick = ext_edge && (!internal_ring_oscillator_cpu_i || ring_tick_i);
         else if (ring_sel)
            count_tick = ring_tick_i;
         else if (presc_cnt + 16'h0001 >= presc_div(prescaler_select[1:0]))
         begin
            count_tick = 1'b1;
            next_presc_cnt = `TCOC_CNT_ZERO;
         end
         else
            next_presc_cnt = presc_cnt + 16'h0001;
      end
      else
         next_presc_cnt = `TCOC_CNT_ZERO;
   end

   // register writes, counter and output flip-flop
   always_comb
   begin
      next_timer_mode_control = timer_mode_control;
      next_capture_compare_control = capture_compare_control;
      next_output_control = output_control;
      next_prescaler_select = prescaler_select;
      next_compare_capture_reg_a = compare_capture_reg_a;
      next_compare_reg_b = compare_reg_b;
      next_timer_count_value = timer_count_value;
      next_ovf = ovf;
      next_out_ff = out_ff;
      next_one_shot_active = one_shot_active;
      next_cap_lo_latch = cap_lo_latch;
      next_run_state = run_state;
      if (op_bits_nonzero)
      begin
         next_run_state = TCOC_RUN;
         if (count_tick)
         begin
            if (clr_on_a && match_a)
               next_timer_count_value = `TCOC_CNT_ZERO;
            else
               next_timer_count_value = timer_count_value + 16'h0001;
            if (timer_count_value == `TCOC_CNT_MAX)
               next_ovf = 1'b1;
            if (output_control[`TCOC_OUT_TOE])
            begin
               if ((match_a && output_control[`TCOC_OUT_INVA]) ^ (match_b && output_control[`TCOC_OUT_INVB]))
                  next_out_ff = ~out_ff;
               if (one_shot_active && match_b)
                  next_one_shot_active = 1'b0;
            end
         end
      end
      else
      begin
         next_run_state = TCOC_IDLE;
         next_timer_count_value = `TCOC_CNT_ZERO;
      end
      if (cap_edge && cap_a_en && op_bits_nonzero)
         next_compare_capture_reg_a = timer_count_value;
      if (bus.wr)
      begin
         if (is_addr(bus.addr, `TCOC_ADDR_MODE))
            next_timer_mode_control = bus.wdata;
         if (is_addr(bus.addr, `TCOC_ADDR_CAPCTL))
            next_capture_compare_control = bus.wdata;
         if (is_addr(bus.addr, `TCOC_ADDR_PRESC))
            next_prescaler_select = bus.wdata;
         if (is_addr(bus.addr, `TCOC_ADDR_CMPA))
            next_compare_capture_reg_a = {bus.wdata, cap_lo_latch};
         if (is_addr(bus.addr, `TCOC_ADDR_CMPB))
            next_compare_reg_b = {bus.wdata, cap_lo_latch};
         if (is_addr(bus.addr, `TCOC_ADDR_COUNT))
            next_cap_lo_latch = bus.wdata;
         // an overflow in the same cycle as the clear wins
         if (is_addr(bus.addr, `TCOC_ADDR_STATUS) && bus.wdata[`TCOC_STAT_OVF] && !ovf_set)
            next_ovf = 1'b0;
         if (is_addr(bus.addr, `TCOC_ADDR_OUTCTL))
         begin
            // level and trigger bits are actions, not stored
            next_output_control = bus.wdata & `TCOC_OUT_RMASK;
            if (bus.wdata[`TCOC_OUT_LVS])
               next_out_ff = 1'b1;
            else if (bus.wdata[`TCOC_OUT_LVR])
               next_out_ff = 1'b0;
            if (bus.wdata[`TCOC_OUT_OSPT] && bus.wdata[`TCOC_OUT_OSPE])
            begin
               next_one_shot_active = 1'b1;
               next_out_ff = 1'b1;
            end
         end
      end
   end

   // read mux, data one cycle after strobe
   always_comb
   begin
      next_rdata = `TCOC_BYTE_ZERO;
      if (bus.rd)
      begin
         case (bus.addr)
            `TCOC_ADDR_MODE: next_rdata = timer_mode_control;
            `TCOC_ADDR_CAPCTL: next_rdata = capture_compare_control;
            `TCOC_ADDR_OUTCTL: next_rdata = output_control & `TCOC_OUT_RMASK;
            `TCOC_ADDR_PRESC: next_rdata = prescaler_select;
            `TCOC_ADDR_CMPA: next_rdata = compare_capture_reg_a[7:0];
            `TCOC_ADDR_CMPB: next_rdata = compare_capture_reg_a[15:8];
            `TCOC_ADDR_COUNT: next_rdata = timer_count_value[7:0];
            `TCOC_ADDR_STATUS: next_rdata = {`TCOC_STAT_PAD, ring_sel, out_ff, op_bits_nonzero, ovf};
            default: next_rdata = `TCOC_BYTE_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         timer_mode_control <= `TCOC_BYTE_ZERO;
         capture_compare_control <= `TCOC_BYTE_ZERO;
         output_control <= `TCOC_BYTE_ZERO;
         prescaler_select <= `TCOC_BYTE_ZERO;
         compare_capture_reg_a <= `TCOC_CNT_ZERO;
         compare_reg_b <= `TCOC_CNT_ZERO;
         timer_count_value <= `TCOC_CNT_ZERO;
         presc_cnt <= `TCOC_CNT_ZERO;
         ovf <= 1'b0;
         out_ff <= 1'b0;
         one_shot_active <= 1'b0;
         cap_lo_latch <= `TCOC_BYTE_ZERO;
         rdata <= `TCOC_BYTE_ZERO;
         run_state <= TCOC_IDLE;
      end
      else
      begin
         timer_mode_control <= next_timer_mode_control;
         capture_compare_control <= next_capture_compare_control;
         output_control <= next_output_control;
         prescaler_select <= next_prescaler_select;
         compare_capture_reg_a <= next_compare_capture_reg_a;
         compare_reg_b <= next_compare_reg_b;
         timer_count_value <= next_timer_count_value;
         presc_cnt <= next_presc_cnt;
         ovf <= next_ovf;
         out_ff <= next_out_ff;
         one_shot_active <= next_one_shot_active;
         cap_lo_latch <= next_cap_lo_latch;
         rdata <= next_rdata;
         run_state <= next_run_state;
      end
   end

   assign rdata_o = rdata;
   assign timer_out_o = out_ff;
   // run is the only state with bit 0 set
   assign running_o = run_state[0];

   property p_lvs_high;
      @(posedge clk_sys_i) disable iff (rst_i)
      (bus.wr && is_addr(bus.addr, `TCOC_ADDR_OUTCTL) && bus.wdata[`TCOC_OUT_LVS]) |=> timer_out_o;
   endproperty
   a_lvs_high: assert property (p_lvs_high) else $error("level set did not raise output");

   property p_lvr_low;
      @(posedge clk_sys_i) disable iff (rst_i)
      (bus.wr && is_addr(bus.addr, `TCOC_ADDR_OUTCTL) && bus.wdata[`TCOC_OUT_LVR] && !bus.wdata[`TCOC_OUT_LVS]
       && !bus.wdata[`TCOC_OUT_OSPT]) |=> !timer_out_o;
   endproperty
   a_lvr_low: assert property (p_lvr_low) else $error("level reset did not lower output");

   property p_level_read_zero;
      @(posedge clk_sys_i) disable iff (rst_i)
      (bus.rd && is_addr(bus.addr, `TCOC_ADDR_OUTCTL)) |=> (rdata_o[`TCOC_OUT_LVS] == 1'b0 && rdata_o[`TCOC_OUT_LVR] == 1'b0);
   endproperty
   a_level_read_zero: assert property (p_level_read_zero) else $error("level bits read non-zero");

   property p_trig_read_zero;
      @(posedge clk_sys_i) disable iff (rst_i)
      (bus.rd && is_addr(bus.addr, `TCOC_ADDR_OUTCTL)) |=> !rdata_o[`TCOC_OUT_OSPT];
   endproperty
   a_trig_read_zero: assert property (p_trig_read_zero) else $error("trigger bit read non-zero");

   property p_run_start;
      @(posedge clk_sys_i) disable iff (rst_i)
      op_bits_nonzero |=> running_o;
   endproperty
   a_run_start: assert property (p_run_start) else $error("counter not running with mode bits set");

   property p_run_stop;
      @(posedge clk_sys_i) disable iff (rst_i)
      !op_bits_nonzero |=> (!running_o && timer_count_value == `TCOC_CNT_ZERO);
   endproperty
   a_run_stop: assert property (p_run_stop) else $error("counter did not stop");

   property p_ring_tick;
      @(posedge clk_sys_i) disable iff (rst_i)
      (op_bits_nonzero && internal_ring_oscillator_cpu_i && !ring_tick_i) |-> !count_tick;
   endproperty
   a_ring_tick: assert property (p_ring_tick) else $error("count tick without ring tick");

   property p_ext_sample;
      @(posedge clk_sys_i) disable iff (rst_i)
      (internal_ring_oscillator_cpu_i && !ring_tick_i) |=> $stable(ext_sync);
   endproperty
   a_ext_sample: assert property (p_ext_sample) else $error("external input sampled off ring tick");

   c_count: cover property (@(posedge clk_sys_i) disable iff (rst_i) running_o && count_tick);
   c_toggle: cover property (@(posedge clk_sys_i) disable iff (rst_i) $rose(timer_out_o));
   c_capture: cover property (@(posedge clk_sys_i) disable iff (rst_i) cap_edge && cap_a_en);
endmodule

// ===== verilog/tcoc_defines.svh
// Purpose: constants for the timer capture and output control block
// Assumes: 8-bit register port, word index addressing
// Notes: offsets and field positions are local choices
`ifndef TCOC_DEFINES_SVH
`define TCOC_DEFINES_SVH
`define TCOC_ADDR_MODE 4'h0
`define TCOC_ADDR_CAPCTL 4'h1
`define TCOC_ADDR_OUTCTL 4'h2
`define TCOC_ADDR_PRESC 4'h3
`define TCOC_ADDR_CMPA 4'h4
`define TCOC_ADDR_CMPB 4'h5
`define TCOC_ADDR_COUNT 4'h6
`define TCOC_ADDR_STATUS 4'h7
`define TCOC_MODE_OPL 0
`define TCOC_MODE_OPH 1
`define TCOC_MODE_CLRA 2
`define TCOC_CAP_A 0
`define TCOC_OUT_INVA 0
`define TCOC_OUT_LVR 2
`define TCOC_OUT_LVS 3
`define TCOC_OUT_INVB 4
`define TCOC_OUT_OSPT 5
`define TCOC_OUT_OSPE 6
`define TCOC_OUT_TOE 0
`define TCOC_OUT_RMASK 8'h53
`define TCOC_PRE_RING 2
`define TCOC_PRE_EXT 2'b11
`define TCOC_STAT_PAD 4'h0
`define TCOC_CNT_MAX 16'hFFFF
`define TCOC_CNT_ZERO 16'h0000
`define TCOC_BYTE_ZERO 8'h00
`define TCOC_STAT_OVF 0
`define TCOC_STAT_RUN 1
`define TCOC_STAT_TO 2
`define TCOC_STAT_RING 3
`endif

// ===== verilog/tcoc_pkg.sv
// Purpose: types for the timer capture and output control block
// Assumes: tcoc_defines.svh supplies the numbers
// Notes: none
package tcoc_pkg;
   typedef struct packed
   {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } tcoc_bus_s;
   typedef enum logic [1:0]
   {
      TCOC_IDLE = 2'b00,
      TCOC_RUN = 2'b01
   } tcoc_run_e;
endpackage

// ===== test/tcoc_pin_model.sv
// Purpose: far-side model of the capture trigger pin, the external count pin and the divided ring oscillator tick
// Assumes: pins are driven on the rising edge of the system clock
// Notes: pins rest low between pulses
module tcoc_pin_model
(
   input wire logic clk_sys_i,
   output logic capture_pin_o,
   output logic ext_count_o,
   output logic ring_tick_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      capture_pin_o = 1'b0;
      ext_count_o = 1'b0;
      ring_tick_o = 1'b0;
   end
   // pulse must exceed one count clock period by two count clocks
   task automatic pulse_capture(input int cycles);
      @(posedge clk_sys_i);
      capture_pin_o <= 1'b1;
      repeat (cycles) @(posedge clk_sys_i);
      capture_pin_o <= 1'b0;
   endtask
   task automatic ext_pulses(input int n);
      repeat (n)
      begin
         @(posedge clk_sys_i);
         ext_count_o <= 1'b1;
         repeat (3) @(posedge clk_sys_i);
         ext_count_o <= 1'b0;
         repeat (3) @(posedge clk_sys_i);
      end
   endtask
   task automatic ring_ticks(input int n);
      repeat (n)
      begin
         @(posedge clk_sys_i);
         ring_tick_o <= 1'b1;
         @(posedge clk_sys_i);
         ring_tick_o <= 1'b0;
      end
   endtask
endmodule

// ===== test/tcoc_top_tb_top.sv
// Purpose: self-checking bench for the timer capture and output control block
// Assumes: register port with read data one cycle after the strobe
// Notes: the timer is halted before every control write except run-mode changes
`include "tcoc_defines.svh"
module tcoc_top_tb_top;
   import tcoc_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic internal_ring_oscillator_cpu_i = 1'b0;
   logic capture_pin, ext_count, ring_tick;
   logic [7:0] rdata_o;
   logic timer_out_o, running_o;
   int err_count = 0;
   int compares = 0;
   int cycles = 0;
   always #2 clk_sys_i = ~clk_sys_i;
   tcoc_pin_model pin_u (.clk_sys_i(clk_sys_i), .capture_pin_o(capture_pin), .ext_count_o(ext_count),
      .ring_tick_o(ring_tick));
   tcoc_top dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .capture_pin_i(capture_pin), .ext_count_pin_i(ext_count), .internal_ring_oscillator_cpu_i(internal_ring_oscillator_cpu_i),
      .ring_tick_i(ring_tick), .rdata_o(rdata_o), .timer_out_o(timer_out_o), .running_o(running_o));
   task automatic give_verdict();
      if (err_count == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk_sys_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_count++;
         give_verdict();
      end
   end
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
      @(posedge clk_sys_i);
      #1;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_sys_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #1;
      d = rdata_o;
   endtask
   task automatic test_reset();
      logic [7:0] d;
      check("out_rst", {7'h00, timer_out_o}, 8'h00);
      check("run_rst", {7'h00, running_o}, 8'h00);
      rd(`TCOC_ADDR_STATUS, d);
      check("stat_rst", d, 8'h00);
      rd(4'h9, d);
      check("unmapped", d, 8'h00);
   endtask
   task automatic test_run_modes();
      logic [7:0] d;
      for (int m = 1; m < 4; m++)
      begin
         wr(`TCOC_ADDR_MODE, 8'(m));
         check("run_on", {7'h00, running_o}, 8'h01);
         rd(`TCOC_ADDR_STATUS, d);
         check("stat_run", d & 8'h02, 8'h02);
         wr(`TCOC_ADDR_MODE, 8'h00);
         check("run_off", {7'h00, running_o}, 8'h00);
      end
   endtask
   task automatic test_output_ff();
      logic [7:0] d;
      wr(`TCOC_ADDR_OUTCTL, 8'h01);
      wr(`TCOC_ADDR_OUTCTL, 8'h09);
      check("out_set", {7'h00, timer_out_o}, 8'h01);
      rd(`TCOC_ADDR_OUTCTL, d);
      check("lvs_rd", d, 8'h01);
      wr(`TCOC_ADDR_OUTCTL, 8'h05);
      check("out_clr", {7'h00, timer_out_o}, 8'h00);
      rd(`TCOC_ADDR_OUTCTL, d);
      check("lvr_rd", d, 8'h01);
      wr(`TCOC_ADDR_OUTCTL, 8'h41);
      wr(`TCOC_ADDR_OUTCTL, 8'h61);
      check("osp_out", {7'h00, timer_out_o}, 8'h01);
      rd(`TCOC_ADDR_OUTCTL, d);
      check("ospt_rd", d, 8'h41);
      wr(`TCOC_ADDR_OUTCTL, 8'h45);
      check("osp_clr", {7'h00, timer_out_o}, 8'h00);
      wr(`TCOC_ADDR_OUTCTL, 8'h61);
      check("osp_again", {7'h00, timer_out_o}, 8'h01);
   endtask
   task automatic test_capture();
      logic [7:0] a0, a1;
      wr(`TCOC_ADDR_COUNT, 8'h00);
      wr(`TCOC_ADDR_CMPA, 8'h80);
      wr(`TCOC_ADDR_CAPCTL, 8'h01);
      wr(`TCOC_ADDR_MODE, 8'h05);
      rd(`TCOC_ADDR_CMPB, a0);
      check("cmpa_hi", a0, 8'h80);
      pin_u.pulse_capture(6);
      repeat (4) @(posedge clk_sys_i);
      rd(`TCOC_ADDR_CMPB, a1);
      check("cap_refused", a1, 8'h80);
      wr(`TCOC_ADDR_MODE, 8'h00);
      wr(`TCOC_ADDR_MODE, 8'h01);
      repeat (20) @(posedge clk_sys_i);
      pin_u.pulse_capture(6);
      repeat (4) @(posedge clk_sys_i);
      rd(`TCOC_ADDR_CMPA, a1);
      check("cap_taken", {7'h00, a1 != 8'h00}, 8'h01);
      rd(`TCOC_ADDR_CMPB, a1);
      check("cap_hi", a1, 8'h00);
      wr(`TCOC_ADDR_MODE, 8'h00);
   endtask
   task automatic test_prescale();
      logic [7:0] d;
      wr(`TCOC_ADDR_PRESC, 8'h01);
      wr(`TCOC_ADDR_MODE, 8'h01);
      repeat (40) @(posedge clk_sys_i);
      rd(`TCOC_ADDR_COUNT, d);
      check("div16", d, 8'h02);
      wr(`TCOC_ADDR_MODE, 8'h00);
      wr(`TCOC_ADDR_PRESC, 8'h03);
      wr(`TCOC_ADDR_MODE, 8'h01);
      pin_u.ext_pulses(3);
      rd(`TCOC_ADDR_COUNT, d);
      check("ext_cnt", d, 8'h03);
      wr(`TCOC_ADDR_MODE, 8'h00);
   endtask
   task automatic test_ring();
      logic [7:0] c0, c1, d;
      wr(`TCOC_ADDR_PRESC, 8'h00);
      @(posedge clk_sys_i);
      internal_ring_oscillator_cpu_i <= 1'b1;
      wr(`TCOC_ADDR_MODE, 8'h01);
      rd(`TCOC_ADDR_COUNT, c0);
      check("ring_start", c0, 8'h00);
      pin_u.ext_pulses(1);
      rd(`TCOC_ADDR_COUNT, c1);
      check("ring_hold", c1, 8'h00);
      pin_u.ring_ticks(4);
      rd(`TCOC_ADDR_COUNT, c1);
      check("ring_tick", c1, 8'h04);
      rd(`TCOC_ADDR_STATUS, d);
      check("ring_stat", d & 8'h08, 8'h08);
      wr(`TCOC_ADDR_MODE, 8'h00);
   endtask
   initial
   begin
      repeat (5) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      @(posedge clk_sys_i);
      #1;
      test_reset();
      test_run_modes();
      test_output_ff();
      test_capture();
      test_prescale();
      test_ring();
      give_verdict();
   end
endmodule
